// [ssc_pkg.sv]
// constants, register map and carrier types of the stand-alone strap configuration block
// assumes one clock domain, a synchronous active-high reset and an AHB-Lite register bus
package ssc_pkg;

	localparam int DIAG_W = 8;

	// byte addresses of the word registers
	localparam logic [7:0] ADDR_STATUS    = 8'h00;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h04;
	localparam logic [7:0] ADDR_FLT_MASK  = 8'h08;
	localparam logic [7:0] ADDR_STRAPS    = 8'h0c;
	localparam logic [7:0] ADDR_CONFIG    = 8'h10;
	localparam logic [7:0] ADDR_DIAG_RAW  = 8'h14;
	localparam int         ADDR_W         = 8;

	// field positions of the strap and config registers
	localparam int POS_RANGE      = 0;
	localparam int POS_PHASE      = 1;
	localparam int POS_HYB_SEL    = 2;
	localparam int POS_HYB_OFF    = 4;
	localparam int POS_SERIAL     = 5;
	localparam int POS_CAPTURED   = 6;
	localparam int HYB_SEL_W      = 2;

	// reset values
	localparam logic [DIAG_W-1:0] RST_FLT_MASK = 8'h00;
	localparam logic [DIAG_W-1:0] RST_IRQ_MASK = 8'h00;

	// htrans encoding bit that marks an active transfer
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY      = 1'h0;

	// crossover fraction codes, full current times 1/16, 1/8, 1/4, 1/2
	typedef enum logic [1:0]
	{
		SSC_XOVER_6P25 = 2'b00,
		SSC_XOVER_12P5 = 2'b01,
		SSC_XOVER_25   = 2'b10,
		SSC_XOVER_50   = 2'b11
	} ssc_xover_t;

	// latched or programmed operating configuration
	typedef struct packed
	{
		logic       rangeHigh;
		logic       phaseShiftEn;
		ssc_xover_t crossover;
		logic       hybridOff;
	} ssc_cfg_t;

	localparam ssc_cfg_t CFG_RESET = '{1'b0, 1'b0, SSC_XOVER_6P25, 1'b1};

	// raw strap pin levels
	typedef struct packed
	{
		logic       serialDisable;
		logic       currentRange;
		logic       phaseShift;
		logic       hybridTiedHigh;
		ssc_xover_t hybridSel;
	} ssc_pins_t;

endpackage

// [ssc_strap_config.sv]
// strap capture, configuration select, fault line and interrupt of the backlight driver
// assumes strap pins asynchronous to clk, diagnostic flags from logic on clk,
// and a single AHB-Lite master with zero-wait single word transfers
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module ssc_strap_config
#(
	parameter int DIAG_W = ssc_pkg::DIAG_W
)
(
	input  wire logic                clk,
	input  wire logic                srst,
	// strap pins
	input  wire logic                serialDisableStrap,
	input  wire logic                currentRangeStrap,
	input  wire logic                phaseShiftStrap,
	input  wire logic                hybridTiedHigh,
	input  wire logic [1:0]          hybridCrossoverSelect,
	// diagnostic flags, levels from detection logic
	input  wire logic [DIAG_W-1:0]   diagFlags,
	// open-drain fault line
	output logic                     faultLineNOut,
	output logic                     faultLineNOe,
	// configuration seen by the analog side, and the interrupt
	output ssc_pkg::ssc_cfg_t        activeCfg,
	output logic                     serialMode,
	output logic                     irq,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic [31:0]              hrdata,
	output logic                     hresp
);

	// whole state of the block
	typedef struct packed
	{
		ssc_pkg::ssc_pins_t      sync1;
		ssc_pkg::ssc_pins_t      sync2;
		logic                    captured;
		ssc_pkg::ssc_pins_t      straps;
		ssc_pkg::ssc_cfg_t       swCfg;
		ssc_pkg::ssc_cfg_t       cfg;
		logic [DIAG_W-1:0]       diagPrev;
		logic [DIAG_W-1:0]       status;
		logic [DIAG_W-1:0]       irqMask;
		logic [DIAG_W-1:0]       fltMask;
		logic                    wrPend;
		logic [ssc_pkg::ADDR_W-1:0] wrAddr;
		logic                    fltDrive;
		logic                    irqOut;
		logic                    serialOut;
		logic [31:0]             rdata;
	} ssc_state_t;

	ssc_state_t stReg;
	ssc_state_t stNext;
	ssc_state_t stReset;

	ssc_pkg::ssc_pins_t pinsNow;
	logic               addrPhase;
	logic [ssc_pkg::ADDR_W-1:0] rdAddr;
	logic [DIAG_W-1:0]  events;
	logic [DIAG_W-1:0]  w1c;
	logic [DIAG_W-1:0]  wData;
	ssc_pkg::ssc_cfg_t  wCfg;

	// pin bundle for the synchroniser
	assign pinsNow = '{serialDisableStrap, currentRangeStrap, phaseShiftStrap,
		hybridTiedHigh, ssc_pkg::ssc_xover_t'(hybridCrossoverSelect)};

	// an address phase is taken only when the bus is ready and the slave is selected
	assign addrPhase = hsel & htrans[ssc_pkg::HTRANS_ACTIVE_BIT] & hready;
	assign rdAddr    = haddr[ssc_pkg::ADDR_W-1:0];

	// flags rising this cycle are the interrupt events
	assign events = diagFlags & ~stReg.diagPrev;

	// write data fields, taken in the data phase
	assign wData = hwdata[DIAG_W-1:0];
	assign wCfg  = '{hwdata[ssc_pkg::POS_RANGE], hwdata[ssc_pkg::POS_PHASE],
		ssc_pkg::ssc_xover_t'(hwdata[ssc_pkg::POS_HYB_SEL +: ssc_pkg::HYB_SEL_W]),
		hwdata[ssc_pkg::POS_HYB_OFF]};

	// write-one-to-clear mask for the status register
	assign w1c = (stReg.wrPend && stReg.wrAddr == ssc_pkg::ADDR_STATUS) ? wData
		: '0;

	// reset image; synchroniser stages keep sampling so the capture sees live pins
	always_comb
	begin
		stReset          = '0;
		stReset.sync1    = pinsNow;
		stReset.sync2    = stReg.sync1;
		stReset.swCfg    = ssc_pkg::CFG_RESET;
		stReset.cfg      = ssc_pkg::CFG_RESET;
		stReset.irqMask  = ssc_pkg::RST_IRQ_MASK;
		stReset.fltMask  = ssc_pkg::RST_FLT_MASK;
		stReset.diagPrev = diagFlags;
	end

	// next-state logic
	always_comb
	begin
		stNext = stReg;

		// two-stage synchroniser, only sync2 is read below
		stNext.sync1 = pinsNow;
		stNext.sync2 = stReg.sync1;

		// one capture, first cycle after release, held until next reset
		if (!stReg.captured)
		begin
			stNext.straps   = stReg.sync2;
			stNext.captured = 1'b1;
		end

		stNext.diagPrev = diagFlags;

		// data phase of a write: registers updated from hwdata
		if (stReg.wrPend)
		begin
			unique case (stReg.wrAddr)
				ssc_pkg::ADDR_IRQ_MASK: stNext.irqMask = wData;
				ssc_pkg::ADDR_FLT_MASK: stNext.fltMask = wData;
				ssc_pkg::ADDR_CONFIG:   stNext.swCfg   = wCfg;
				default:                stNext.wrPend  = 1'b0; // unmapped, read-only or status (status is cleared through w1c)
			endcase
		end

		// sticky status, a new event beats a clear in the same cycle
		stNext.status = (stReg.status & ~w1c) | events;

		// straps decide the mode; serial mode takes config from software
		if (stNext.straps.serialDisable)
		begin
			// stand-alone: shared pins act as straps
			stNext.cfg.rangeHigh    = stNext.straps.currentRange;
			stNext.cfg.phaseShiftEn = stNext.straps.phaseShift;
			stNext.cfg.crossover    = stNext.straps.hybridSel;
			stNext.cfg.hybridOff    = stNext.straps.hybridTiedHigh;
		end
		else
		begin
			stNext.cfg = stNext.swCfg;
		end

		// no valid straps before capture: keep the safe reset configuration
		if (!stNext.captured)
		begin
			stNext.cfg = ssc_pkg::CFG_RESET;
		end

		// open drain pulls low while an unmasked flag is set
		stNext.fltDrive = |(diagFlags & ~stNext.fltMask);
		stNext.irqOut   = |(stNext.status & stNext.irqMask);
		// registered so the mode output comes straight from a flip-flop
		stNext.serialOut = stNext.captured & ~stNext.straps.serialDisable;

		// address phase: latch write target, prepare read data for the data phase
		stNext.wrPend = addrPhase & hwrite;
		stNext.wrAddr = rdAddr;
		stNext.rdata  = '0;
		if (addrPhase && !hwrite)
		begin
			// read mux sees the outcome of a write finishing this cycle
			unique case (rdAddr)
				ssc_pkg::ADDR_STATUS:   stNext.rdata[DIAG_W-1:0] = stNext.status;
				ssc_pkg::ADDR_IRQ_MASK: stNext.rdata[DIAG_W-1:0] = stNext.irqMask;
				ssc_pkg::ADDR_FLT_MASK: stNext.rdata[DIAG_W-1:0] = stNext.fltMask;
				ssc_pkg::ADDR_DIAG_RAW: stNext.rdata[DIAG_W-1:0] = diagFlags;
				ssc_pkg::ADDR_STRAPS:
				begin
					stNext.rdata[ssc_pkg::POS_RANGE]    = stNext.straps.currentRange;
					stNext.rdata[ssc_pkg::POS_PHASE]    = stNext.straps.phaseShift;
					stNext.rdata[ssc_pkg::POS_HYB_SEL +: ssc_pkg::HYB_SEL_W] =
						stNext.straps.hybridSel;
					stNext.rdata[ssc_pkg::POS_HYB_OFF]  = stNext.straps.hybridTiedHigh;
					stNext.rdata[ssc_pkg::POS_SERIAL]   = ~stNext.straps.serialDisable;
					stNext.rdata[ssc_pkg::POS_CAPTURED] = stNext.captured;
				end
				ssc_pkg::ADDR_CONFIG:
				begin
					// shows the configuration in force, not only the software copy
					stNext.rdata[ssc_pkg::POS_RANGE]    = stNext.cfg.rangeHigh;
					stNext.rdata[ssc_pkg::POS_PHASE]    = stNext.cfg.phaseShiftEn;
					stNext.rdata[ssc_pkg::POS_HYB_SEL +: ssc_pkg::HYB_SEL_W] =
						stNext.cfg.crossover;
					stNext.rdata[ssc_pkg::POS_HYB_OFF]  = stNext.cfg.hybridOff;
				end
				default: stNext.rdata = '0; // unmapped reads as zero
			endcase
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stReg <= stReset;
		end
		else
		begin
			stReg <= stNext;
		end
	end

	// outputs straight from the state register, except the constant fault data, ready and response
	assign faultLineNOut = 1'b0;           // open drain only ever pulls low
	assign faultLineNOe  = stReg.fltDrive;
	assign activeCfg     = stReg.cfg;
	assign serialMode    = stReg.serialOut;
	assign irq           = stReg.irqOut;
	assign hrdata        = stReg.rdata;
	// zero wait states, so ready and response are tied constants
	assign hreadyout     = 1'b1;
	assign hresp         = ssc_pkg::HRESP_OKAY;

endmodule

// [ssc_strap_checker.sv]
// port-level assertions for the strap configuration block
// assumes strap pins held steady around each reset release
`timescale 1ns/1ns
module ssc_strap_checker
#(
	parameter int DIAG_W = 8
)
(
	input wire logic              clk,
	input wire logic              srst,
	input wire logic              serialDisableStrap,
	input wire logic              currentRangeStrap,
	input wire logic              phaseShiftStrap,
	input wire logic              hybridTiedHigh,
	input wire logic [1:0]        hybridCrossoverSelect,
	input wire logic [DIAG_W-1:0] diagFlags,
	input wire logic              faultLineNOut,
	input wire logic              faultLineNOe,
	input wire ssc_pkg::ssc_cfg_t activeCfg,
	input wire logic              serialMode
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// two quiet cycles of flags, and the edge that captures straps
	sequence flagsQuiet;
		(diagFlags == '0) [*2];
	endsequence
	sequence captureEdge;
		$past(srst) && !srst;
	endsequence
	AST_OUT_LOW: assert property (!faultLineNOut)
		else $error("fault data not low");
	AST_OE_CAUSE: assert property ($rose(faultLineNOe) |-> $past(diagFlags) != '0)
		else $error("fault line pulled without flag");
	AST_OE_QUIET: assert property (flagsQuiet |-> !faultLineNOe)
		else $error("fault line pulled while flags clear");
	AST_CAP_MODE: assert property (captureEdge |=> serialMode == !$past(serialDisableStrap))
		else $error("mode not taken from strap");
	AST_CAP_STRAP: assert property (captureEdge ##0 serialDisableStrap |=>
		activeCfg.rangeHigh == $past(currentRangeStrap)
		&& activeCfg.phaseShiftEn == $past(phaseShiftStrap))
		else $error("range or phase strap not captured");
	AST_CAP_HYB: assert property (captureEdge ##0 serialDisableStrap |=>
		activeCfg.hybridOff == $past(hybridTiedHigh)
		&& (activeCfg.hybridOff || activeCfg.crossover == $past(hybridCrossoverSelect)))
		else $error("hybrid setting not captured");
	AST_CFG_HOLD: assert property (!serialMode && !$past(srst) |=> $stable(activeCfg))
		else $error("stand-alone config changed");
	AST_MODE_HOLD: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(serialMode))
		else $error("mode changed after capture");
endmodule
bind ssc_strap_config ssc_strap_checker #(.DIAG_W(DIAG_W)) chk (.clk(clk), .srst(srst),
	.serialDisableStrap(serialDisableStrap), .currentRangeStrap(currentRangeStrap),
	.phaseShiftStrap(phaseShiftStrap), .hybridTiedHigh(hybridTiedHigh),
	.hybridCrossoverSelect(hybridCrossoverSelect), .diagFlags(diagFlags),
	.faultLineNOut(faultLineNOut), .faultLineNOe(faultLineNOe), .activeCfg(activeCfg),
	.serialMode(serialMode));

// [ssc_board.sv]
// board model: strap wiring and the pulled-up fault line the host watches
// assumes the bench picks strap levels
`timescale 1ns/1ns
module ssc_board
(
	input  wire logic               faultLineNOut,
	input  wire logic               faultLineNOe,
	input  wire ssc_pkg::ssc_pins_t straps,
	output ssc_pkg::ssc_pins_t      pins,
	output logic                    faultLine
);
	// straps are fixed wiring, no drive strength modelled
	assign pins = straps;
	// pull-up wins while the device releases the line
	assign faultLine = faultLineNOe ? faultLineNOut : 1'b1;
endmodule

// [tb.sv]
// self-checking bench for the strap configuration block
// assumes a zero-wait bus slave and the board model beside it
`timescale 1ns/1ns
module tb;
	logic               clk = 1'b0;
	logic               srst = 1'b1;
	ssc_pkg::ssc_pins_t straps = '0;
	ssc_pkg::ssc_pins_t pins;
	ssc_pkg::ssc_pins_t p;
	ssc_pkg::ssc_cfg_t  activeCfg;
	logic [7:0]         diagFlags = '0;
	logic [7:0]         f;
	logic               hsel = 1'b0;
	logic               hwrite = 1'b0;
	logic [1:0]         htrans = 2'b00;
	logic [31:0]        haddr = '0;
	logic [31:0]        hwdata = '0;
	logic [31:0]        hrdata;
	logic [31:0]        rd;
	logic               faultLineNOut, faultLineNOe, serialMode, irq, hreadyout, hresp;
	logic               faultLine;
	int                 num_errors = 0;
	int                 check_count = 0;
	int                 i;
	always #50 clk = ~clk;
	ssc_strap_config DUT (.clk(clk), .srst(srst), .serialDisableStrap(pins.serialDisable),
		.currentRangeStrap(pins.currentRange), .phaseShiftStrap(pins.phaseShift),
		.hybridTiedHigh(pins.hybridTiedHigh), .hybridCrossoverSelect(pins.hybridSel),
		.diagFlags(diagFlags), .faultLineNOut(faultLineNOut), .faultLineNOe(faultLineNOe),
		.activeCfg(activeCfg), .serialMode(serialMode), .irq(irq), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	ssc_board board (.faultLineNOut(faultLineNOut), .faultLineNOe(faultLineNOe),
		.straps(straps), .pins(pins), .faultLine(faultLine));
	// compare and count
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// bounded wait for the slave's ready
	task automatic waitReady();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
	endtask
	// one single-word transfer, address phase then data phase
	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		waitReady();
		q = hrdata;
	endtask
	// serial mode keeps the reset config until software writes one
	function automatic ssc_pkg::ssc_cfg_t expCfg(ssc_pkg::ssc_pins_t s);
		expCfg = s.serialDisable ? ssc_pkg::ssc_cfg_t'({s.currentRange, s.phaseShift,
			s.hybridSel, s.hybridTiedHigh}) : ssc_pkg::CFG_RESET;
	endfunction
	// crossover is ignored while hybrid dimming is off
	task automatic chkCfg(ssc_pkg::ssc_pins_t s);
		logic [4:0] m;
		m = s.hybridTiedHigh ? 5'h19 : 5'h1f;
		check("mode", serialMode, !s.serialDisable);
		check("cfg", 5'(activeCfg) & m, 5'(expCfg(s)) & m);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// watchdog at 10000 cycles, far beyond the roughly 150 cycles the tests need
	initial
	begin
		#1000000;
		num_errors++;
		complete_run();
	end
	// strap capture per mode and code, then fault line and interrupt
	initial
	begin
		void'($urandom(5));
		for (i = 0; i < 6; i++)
		begin
			p = ssc_pkg::ssc_pins_t'($urandom);
			p.serialDisable = (i != 0);
			p.hybridTiedHigh = (i == 5);
			p.hybridSel = ssc_pkg::ssc_xover_t'(i - 1);
			@(posedge clk);
			straps <= p;
			srst <= 1'b1;
			repeat (4) @(posedge clk);
			srst <= 1'b0;
			repeat (3) @(posedge clk);
			chkCfg(p);
			straps <= ssc_pkg::ssc_pins_t'($urandom);
			repeat (4) @(posedge clk);
			chkCfg(p);
			bus(1'b0, ssc_pkg::ADDR_STRAPS, '0, rd);
			check("straps", rd, 32'({1'b1, !p.serialDisable, p.hybridTiedHigh, p.hybridSel,
				p.phaseShift, p.currentRange}));
			check("hresp", hresp, 1'b0);
			check("hready", hreadyout, 1'b1);
			if (i == 0)
			begin
				f = 8'($urandom) & 8'h1f;
				bus(1'b1, ssc_pkg::ADDR_CONFIG, {24'h0, f}, rd);
				repeat (2) @(posedge clk);
				check("scfg", 5'(activeCfg), {f[0], f[1], f[3:2], f[4]});
			end
			$display("strap test %0d done", i);
		end
		bus(1'b0, ssc_pkg::ADDR_FLT_MASK, '0, rd);
		check("fmask", rd, 32'h0);
		bus(1'b1, 8'h40, 32'hffffffff, rd);
		bus(1'b0, 8'h40, '0, rd);
		check("unmapped", rd, 32'h0);
		f = 8'($urandom) | 8'h01;
		diagFlags <= f;
		repeat (2) @(posedge clk);
		check("fault", faultLine, 1'b0);
		bus(1'b0, ssc_pkg::ADDR_DIAG_RAW, '0, rd);
		check("diagraw", rd, {24'h0, f});
		bus(1'b1, ssc_pkg::ADDR_FLT_MASK, {24'h0, f}, rd);
		repeat (2) @(posedge clk);
		check("fmasked", faultLine, 1'b1);
		bus(1'b1, ssc_pkg::ADDR_FLT_MASK, {24'h0, f & 8'hfe}, rd);
		repeat (2) @(posedge clk);
		check("funmask", faultLine, 1'b0);
		diagFlags <= 8'h00;
		$display("fault test done");
		bus(1'b1, ssc_pkg::ADDR_IRQ_MASK, 32'hff, rd);
		bus(1'b1, ssc_pkg::ADDR_STATUS, 32'hff, rd);
		repeat (2) @(posedge clk);
		check("irqclr", irq, 1'b0);
		diagFlags <= 8'h80;
		repeat (3) @(posedge clk);
		check("irqset", irq, 1'b1);
		bus(1'b0, ssc_pkg::ADDR_STATUS, '0, rd);
		check("status", rd, 32'h80);
		bus(1'b1, ssc_pkg::ADDR_IRQ_MASK, 32'h0, rd);
		repeat (2) @(posedge clk);
		check("irqmask", irq, 1'b0);
		$display("irq test done");
		complete_run();
	end
endmodule
